// ### core/bus_response_target_ready.sv
// Response phase, target-ready and mode-entry logic of one bus agent.
// Assumes pins are sampled on i_ref_clk; an outer pad ring resolves the *_oe_n pairs.
// What this block does
// [RL1] Drive response parity in the same clocks as the three response status lines.
// [RL2] Parity pin is high for an even count of low covered lines, else low.
// [RL3] Idle status 000 leaves parity undriven; it floats high and stays correct.
// [RL4] Check parity every clock; a mismatch is flagged as a protocol violation.
// [RL5] If enabled at configuration, a parity error drives the bus init error line.
// [RL6] Interrupt taken asynchronously: save state, enter mode, acknowledge, start handler.
// [RL7] Mark management-memory fetches in mode on line 4 in request clock two.
// [RL8] Split-lock flag only in clock two of a locked operation's first transaction.
// [RL9] Stop request: enter low power, acknowledge, gate all but bus and interrupt units.
// [RL10] While stopped keep snooping; on release restart clocks; bus clock never gated.
// [RL11] Stop request is asynchronous, but synchronous in redundancy-check mode.
// [RL12] Target-ready lets the initiator or snooper start write or write-back data.
// [RL13] A zero-length write moves no data after target-ready.
// [RL14] Full-line write with write-back: own write data transfer is optional.
// [RL15] Target asserts write target-ready only with data, buffer, spacing and queue top.
// [RL16] Write-back target-ready needs a write-back snoop, a line buffer and spacing.
// [RL17] With both transfers, target-ready drops at least one clock between them.
// [RL18] Target-ready may drop once seen with data-bus-busy inactive.
// [RL19] Target-ready drops are at least three clocks apart.
// [RL20] Target-ready may also drop on the response or before a separate write-back.
// [RL21] A response drives status nonzero for exactly one clock.
// [RL22] Status codes: retry, defer, reserved, failure, no data, write-back, data.
// [RL23] Parity is computed from the driven status so both leave in one clock.
module bus_response_target_ready
   import bus_resp_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   // Response lines as seen on the bus (electrical levels)
   input  wire logic [2:0] i_response_status_n,
   input  wire logic       i_response_parity,
   input  wire logic       i_bus_init_enable,
   // Local response request (asserted-sense code, one cycle)
   input  wire logic       i_rsp_valid,
   input  wire logic [2:0] i_rsp_code,
   output logic [2:0]      o_response_status_n,
   output logic            o_response_status_oe_n,
   output logic            o_response_parity,
   output logic            o_response_parity_oe_n,
   output logic            o_protocol_error,
   output logic            o_bus_init_error_n,
   output logic            o_bus_init_error_oe_n,
   // Initiator side of the data handshake
   input  wire logic       i_target_ready_n,
   input  wire logic       i_data_bus_busy_n,
   input  wire logic       i_wr_pending,
   input  wire logic       i_wr_len_zero,
   input  wire logic       i_full_line_iwb,
   output logic            o_write_data_start,
   // Request phase attributes
   input  wire logic       i_req_second_clk,
   input  wire logic       i_fetch_mgmt_space,
   input  wire logic       i_lock_first,
   output logic            o_ext_function_line_4_n,
   output logic            o_ext_function_line_3_n,
   output logic            o_ext_function_oe_n,
   // Mode entry
   input  wire logic       i_system_mgmt_interrupt_n,
   input  wire logic       i_stop_clock_request_n,
   input  wire logic       i_redundancy_check_mode,
   input  wire logic       i_ack_done,
   input  wire logic       i_smm_resume,
   output logic [1:0]      o_ack_req,
   output logic            o_save_state,
   output logic            o_handler_start,
   output logic            o_system_management_mode,
   output logic            o_core_clock_gate
);

   agent_state_e state_q;
   rsp_s         drive_q;
   logic         driving_q;
   logic         smi_sync_n;
   logic         stop_sync_n;
   logic         stop_req;
   logic         smm_q;
   logic         seen_parity_err;
   logic [2:0]   obs_status;

   // Asynchronous pins are synchronised before use, except the stop request in redundancy-check mode
   level_sync #(.RESET_VALUE(1'b1)) u_smi_sync (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .i_async   (i_system_mgmt_interrupt_n),
      .o_sync    (smi_sync_n)
   );

   level_sync #(.RESET_VALUE(1'b1)) u_stop_sync (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .i_async   (i_stop_clock_request_n),
      .o_sync    (stop_sync_n)
   );

   assign stop_req = i_redundancy_check_mode ? ~i_stop_clock_request_n : ~stop_sync_n; // [RL11]

   // Response drive: one clock of status with its parity
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         drive_q   <= '{status: RS_IDLE, parity: 1'b1};
         driving_q <= 1'b0;
      end else if (i_rsp_valid && i_rsp_code != RS_IDLE && !driving_q) begin
         drive_q   <= '{status: i_rsp_code, parity: parity_of(i_rsp_code)}; // [RL22] [RL23]
         driving_q <= 1'b1;                                                // [RL21]
      end else begin
         drive_q   <= '{status: RS_IDLE, parity: 1'b1};
         driving_q <= 1'b0;                                                // [RL21]
      end
   end

   assign o_response_status_n    = ~drive_q.status;
   assign o_response_status_oe_n = ~driving_q;
   assign o_response_parity      = drive_q.parity;                         // [RL1] [RL2]
   assign o_response_parity_oe_n = ~driving_q;                             // [RL3]

   // Parity check on every clock
   assign obs_status      = ~i_response_status_n;
   assign seen_parity_err = i_response_parity != parity_of(obs_status);    // [RL4]

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         o_protocol_error      <= 1'b0;
         o_bus_init_error_n    <= 1'b1;
         o_bus_init_error_oe_n <= 1'b1;
      end else begin
         o_protocol_error      <= seen_parity_err;                         // [RL4]
         o_bus_init_error_n    <= 1'b0;
         o_bus_init_error_oe_n <= ~(seen_parity_err && i_bus_init_enable); // [RL5]
      end
   end

   // Initiator data start on target-ready with the data bus free
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         o_write_data_start <= 1'b0;
      end else begin
         o_write_data_start <= !i_target_ready_n && i_data_bus_busy_n     // [RL12] [RL18]
                               && i_wr_pending && !i_wr_len_zero          // [RL13]
                               && !i_full_line_iwb;                       // [RL14]
      end
   end

   // Request phase attribute flags
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         o_ext_function_line_4_n <= 1'b1;
         o_ext_function_line_3_n <= 1'b1;
         o_ext_function_oe_n     <= 1'b1;
      end else begin
         o_ext_function_line_4_n <= ~(i_req_second_clk && smm_q && i_fetch_mgmt_space); // [RL7]
         o_ext_function_line_3_n <= ~(i_req_second_clk && i_lock_first);                // [RL8]
         o_ext_function_oe_n     <= ~i_req_second_clk;
      end
   end

   // Mode entry sequencing
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         state_q <= ST_RUN;
      end else begin
         unique case (state_q)
            ST_RUN: begin
               if (!smi_sync_n && !smm_q) begin
                  state_q <= ST_SMI_SAVE;                                  // [RL6]
               end else if (stop_req) begin
                  state_q <= ST_STOP_ACK;                                  // [RL9]
               end
            end
            ST_SMI_SAVE:  state_q <= ST_SMI_ACK;
            ST_SMI_ACK: begin
               if (i_ack_done) begin
                  state_q <= ST_SMI_ENTER;
               end
            end
            ST_SMI_ENTER: state_q <= ST_RUN;
            ST_STOP_ACK: begin
               if (i_ack_done) begin
                  state_q <= ST_STOPPED;
               end
            end
            ST_STOPPED: begin
               if (!stop_req) begin
                  state_q <= ST_RUN;                                       // [RL10]
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         smm_q <= 1'b0;
      end else if (state_q == ST_SMI_SAVE) begin
         smm_q <= 1'b1;                                                    // [RL6]
      end else if (i_smm_resume) begin
         smm_q <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         o_ack_req                <= ACK_NONE;
         o_save_state             <= 1'b0;
         o_handler_start          <= 1'b0;
         o_system_management_mode <= 1'b0;
         o_core_clock_gate        <= 1'b0;
      end else begin
         o_save_state             <= state_q == ST_RUN && !smi_sync_n && !smm_q; // [RL6]
         o_handler_start          <= state_q == ST_SMI_ACK && i_ack_done;       // [RL6]
         o_system_management_mode <= smm_q;
         // Only core units are gated; the bus and interrupt units keep running
         o_core_clock_gate        <= state_q == ST_STOPPED && stop_req;         // [RL9] [RL10]
         if (state_q == ST_SMI_ACK && !i_ack_done) begin
            o_ack_req <= ACK_SMI;                                              // [RL6]
         end else if (state_q == ST_STOP_ACK && !i_ack_done) begin
            o_ack_req <= ACK_STOPCLK;                                          // [RL9]
         end else begin
            o_ack_req <= ACK_NONE;
         end
      end
   end

   // Checks
   chk_resp_one_clock: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL21]
      !o_response_status_oe_n |=> o_response_status_oe_n)
      else $error("response held longer than one clock");
   chk_parity_with_status: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL1]
      o_response_parity_oe_n == o_response_status_oe_n)
      else $error("parity not driven with status");
   chk_parity_value: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL2]
      i_rsp_valid && i_rsp_code == RS_DATA && o_response_status_oe_n
      |=> !o_response_parity && o_response_status_n == 3'h0)
      else $error("wrong parity for data response");
   chk_idle_undriven: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL3]
      o_response_status_oe_n |-> o_response_parity && o_response_status_n == 3'h7)
      else $error("idle response lines not released high");
   chk_parity_error: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL4]
      (i_response_parity != ~(^(~i_response_status_n))) |=> o_protocol_error)
      else $error("parity error not flagged");
   chk_init_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL5]
      !i_bus_init_enable |=> o_bus_init_error_oe_n)
      else $error("bus init error driven while disabled");
   chk_mgmt_flag: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL7]
      !o_ext_function_line_4_n |-> $past(i_req_second_clk) && $past(smm_q))
      else $error("management flag outside mode or clock two");
   chk_split_lock: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL8]
      !o_ext_function_line_3_n |-> $past(i_lock_first) && !o_ext_function_oe_n)
      else $error("split lock flag misplaced");
   chk_smi_sequence: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL6]
      o_save_state |=> ##[0:1] o_ack_req == ACK_SMI || $past(i_ack_done))
      else $error("no acknowledge after state save");
   chk_gate_release: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL10]
      o_core_clock_gate && !stop_req |=> !o_core_clock_gate)
      else $error("core clocks not restarted");
   chk_zero_len: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // [RL13]
      i_wr_len_zero |=> !o_write_data_start)
      else $error("data started for zero length write");

   cov_response: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !o_response_status_oe_n && o_response_status_n == 3'h1);
   cov_smi_entry: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_handler_start);
   cov_stop_clock: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_core_clock_gate ##1 !o_core_clock_gate);
   cov_write_start: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_write_data_start);

endmodule // bus_response_target_ready

// ### core/bus_resp_pkg.sv
// Shared constants, types and helpers for the response and target-ready block.
// Assumes all bus pins are sampled on the bus clock; pin levels are electrical (low = asserted).
package bus_resp_pkg;

   // Response status encodings, asserted sense
   localparam logic [2:0] RS_IDLE     = 3'h0;
   localparam logic [2:0] RS_RETRY    = 3'h1;
   localparam logic [2:0] RS_DEFER    = 3'h2;
   localparam logic [2:0] RS_RESERVED = 3'h3;
   localparam logic [2:0] RS_HARDFAIL = 3'h4;
   localparam logic [2:0] RS_NODATA   = 3'h5;
   localparam logic [2:0] RS_IWB      = 3'h6;
   localparam logic [2:0] RS_DATA     = 3'h7;

   // Special transaction codes for acknowledge cycles
   localparam logic [1:0] ACK_NONE    = 2'h0;
   localparam logic [1:0] ACK_SMI     = 2'h1;
   localparam logic [1:0] ACK_STOPCLK = 2'h2;

   // Depth of the input synchroniser
   localparam int unsigned SYNC_STAGES = 2;

   typedef struct packed {
      logic [2:0] status;
      logic       parity;
   } rsp_s;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_SMI_SAVE,
      ST_SMI_ACK,
      ST_SMI_ENTER,
      ST_STOP_ACK,
      ST_STOPPED
   } agent_state_e;

   // Pin level of correct parity: high when the number of low lines is even
   function automatic logic parity_of(input logic [2:0] status);
      parity_of = ~(^status);
   endfunction

endpackage

// ### core/level_sync.sv
// Two-stage synchroniser for one asynchronous level input.
// Assumes the reset is synchronous to the same clock.
module level_sync #(
   parameter logic RESET_VALUE = 1'b1
) (
   input  wire logic i_ref_clk,
   input  wire logic i_reset_n,
   input  wire logic i_async,
   output logic      o_sync
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         meta_q <= RESET_VALUE;
         sync_q <= RESET_VALUE;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule // level_sync

// ### test/bus_agent_model.sv
// Behavioural far-side agent: response agent, write target and data bus owner.
// Assumes bench commands change just after the falling edge of i_ref_clk.
module bus_agent_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_send,
   input  wire logic [2:0] i_code,
   input  wire logic       i_bad_parity,
   input  wire logic       i_target_ready_req,
   input  wire logic       i_busy,
   output logic [2:0]      o_response_status_n,
   output logic            o_response_parity,
   output logic            o_target_ready_n,
   output logic            o_data_bus_busy_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] gap_q;
   initial begin
      o_response_status_n = 3'h7;
      o_response_parity   = 1'b1;
      o_target_ready_n    = 1'b1;
      o_data_bus_busy_n   = 1'b1;
      gap_q               = 3'h7;
   end
   always @(posedge i_ref_clk) begin
      // One-clock response; when idle the pull-up holds parity high
      o_response_status_n <= i_send ? ~i_code : 3'h7;
      o_response_parity <= i_send ? ~(^i_code) ^ i_bad_parity : 1'b1;
      o_data_bus_busy_n <= ~i_busy;
      gap_q <= (gap_q == 3'h7) ? gap_q : gap_q + 3'h1;
      if (o_target_ready_n && i_target_ready_req && gap_q >= 3'h2) begin
         o_target_ready_n <= 1'b0;
      end else if (!o_target_ready_n && o_data_bus_busy_n && gap_q >= 3'h3) begin
         o_target_ready_n <= 1'b1;
         gap_q <= 3'h0;
      end
   end
endmodule // bus_agent_model

// ### test/test_bus_response_target_ready.sv
// Self-checking bench for the response and target-ready block.
// Assumes the far-side agent model and the design package are compiled first.
module test_bus_response_target_ready;
   timeunit 1ns;
   timeprecision 1ps;
   import bus_resp_pkg::*;
   logic       clk, reset_n, init_en, rsp_valid, wr_pend, wr_zero, full_iwb, req2, fetch;
   logic       lock1, smi_n, stop_n, redundancy_check_mode, ack_done, resume, ag_send, ag_bad, target_ready_req, busy;
   logic [2:0] rsp_code, ag_code, rs_n, ag_rs_n, rs_pin;
   logic       rs_oe_n, par, par_oe_n, perr, bus_init_error_n, bus_init_error_oe_n, wstart, ef4_n, ef3_n;
   logic       ef_oe_n, save, hstart, system_management_mode, gate, ag_par, target_ready_n, data_bus_busy_n, par_pin, mode_exp;
   logic [1:0] ack_req;
   int         fails, checks_done, seed;
   assign rs_pin  = rs_oe_n ? ag_rs_n : rs_n;
   assign par_pin = par_oe_n ? ag_par : par;
   bus_response_target_ready u_bus_response_target_ready (
      .i_ref_clk(clk), .i_reset_n(reset_n), .i_response_status_n(rs_pin),
      .i_response_parity(par_pin), .i_bus_init_enable(init_en), .i_rsp_valid(rsp_valid),
      .i_rsp_code(rsp_code), .o_response_status_n(rs_n), .o_response_status_oe_n(rs_oe_n),
      .o_response_parity(par), .o_response_parity_oe_n(par_oe_n), .o_protocol_error(perr),
      .o_bus_init_error_n(bus_init_error_n), .o_bus_init_error_oe_n(bus_init_error_oe_n),
      .i_target_ready_n(target_ready_n), .i_data_bus_busy_n(data_bus_busy_n), .i_wr_pending(wr_pend),
      .i_wr_len_zero(wr_zero), .i_full_line_iwb(full_iwb), .o_write_data_start(wstart),
      .i_req_second_clk(req2), .i_fetch_mgmt_space(fetch), .i_lock_first(lock1),
      .o_ext_function_line_4_n(ef4_n), .o_ext_function_line_3_n(ef3_n),
      .o_ext_function_oe_n(ef_oe_n), .i_system_mgmt_interrupt_n(smi_n),
      .i_stop_clock_request_n(stop_n), .i_redundancy_check_mode(redundancy_check_mode), .i_ack_done(ack_done),
      .i_smm_resume(resume), .o_ack_req(ack_req), .o_save_state(save),
      .o_handler_start(hstart), .o_system_management_mode(system_management_mode), .o_core_clock_gate(gate));
   bus_agent_model u_bus_agent_model (
      .i_ref_clk(clk), .i_send(ag_send), .i_code(ag_code), .i_bad_parity(ag_bad),
      .i_target_ready_req(target_ready_req), .i_busy(busy), .o_response_status_n(ag_rs_n),
      .o_response_parity(ag_par), .o_target_ready_n(target_ready_n), .o_data_bus_busy_n(data_bus_busy_n));
   function automatic logic exp_par(input logic [2:0] code);
      return ($countones(code) % 2) == 0;
   endfunction
   function automatic logic pick(input int k);
      case (k)
         0: return save === 1'b1;
         1: return ack_req === 2'h2;
         2: return gate === 1'b1;
         default: return gate === 1'b0;
      endcase
   endfunction
   task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wait_hi(input int k);
      int n;
      n = 0;
      while (!pick(k) && n < 30) begin
         @(negedge clk);
         n++;
      end
      chk({3'h0, pick(k)}, 4'h1, "bounded wait");
      if (n == 30) give_verdict();
   endtask
   // Random traffic: bad parity, target-ready handshakes and request flags
   task automatic run_random(input int n);
      logic [3:0] e_err, e_start, e_flag;
      logic       f2, bad;
      f2 = 1'b0;
      for (int i = 0; i <= n; i++) begin
         if (i > 0) begin
            chk({1'b0, bus_init_error_n, perr, bus_init_error_oe_n}, e_err, "parity check");
            chk({3'h0, wstart}, e_start, "write start");
            chk({1'b0, ef_oe_n, f2 ? {ef3_n, ef4_n} : 2'h0}, e_flag, "flags");
         end
         {ag_send, ag_bad, init_en, target_ready_req, busy, wr_pend} = 6'($random(seed));
         {wr_zero, full_iwb, req2, fetch, lock1} = 5'($random(seed));
         ag_code = 3'($random(seed));
         bad = par_pin !== exp_par(~rs_pin);
         e_err = {2'h0, bad, !(bad && init_en)};
         e_start = {3'h0, !target_ready_n && data_bus_busy_n && wr_pend && !wr_zero && !full_iwb};
         e_flag = {1'b0, !req2, req2 ? {!lock1, !(fetch && mode_exp)} : 2'h0};
         f2 = req2;
         @(negedge clk);
      end
      {ag_send, req2, target_ready_req, wr_pend} = 4'h0;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      seed = 32'h8836D804;
      mode_exp = 1'b0;
      {reset_n, init_en, rsp_valid, wr_pend, wr_zero, full_iwb, req2, fetch, lock1} = 9'h0;
      {redundancy_check_mode, ack_done, resume, ag_send, ag_bad, target_ready_req, busy} = 7'h0;
      {smi_n, stop_n} = 2'h3;
      {rsp_code, ag_code} = 6'h0;
      fails = 0;
      checks_done = 0;
      repeat (5) @(negedge clk);
      chk({rs_oe_n, par_oe_n, ef_oe_n, bus_init_error_oe_n}, 4'hF, "reset enables");
      chk({rs_n, par}, 4'hF, "reset pins");
      reset_n = 1'b1;
      // Every code, held over the driving cycle so the repeat is refused
      for (int c = 0; c < 8; c++) begin
         rsp_valid = 1'b1;
         rsp_code = 3'(c);
         @(negedge clk);
         chk({2'h0, rs_oe_n, par_oe_n}, c == 0 ? 4'h3 : 4'h0, "enables");
         chk({rs_n, par}, {~rsp_code, exp_par(rsp_code)}, "drive");
         @(negedge clk);
         chk({2'h0, rs_oe_n, perr}, 4'h2, "released");
         rsp_valid = 1'b0;
         @(negedge clk);
      end
      run_random(300);
      smi_n = 1'b0;
      wait_hi(0);
      smi_n = 1'b1;
      // Mode output and acknowledge both show two clocks after the save pulse
      repeat (2) @(negedge clk);
      mode_exp = 1'b1;
      chk({3'h0, system_management_mode}, 4'h1, "mode entered");
      chk({2'h0, ack_req}, 4'h1, "interrupt ack");
      ack_done = 1'b1;
      @(negedge clk);
      ack_done = 1'b0;
      chk({1'b0, ack_req, hstart}, 4'h1, "handler start");
      run_random(100);
      resume = 1'b1;
      mode_exp = 1'b0;
      @(negedge clk);
      resume = 1'b0;
      repeat (2) @(negedge clk);
      chk({3'h0, system_management_mode}, 4'h0, "mode left");
      // Synchronised path first, so the direct path starts from a settled synchroniser
      for (int m = 0; m < 2; m++) begin
         redundancy_check_mode = 1'(m);
         stop_n = 1'b0;
         wait_hi(1);
         ack_done = 1'b1;
         @(negedge clk);
         ack_done = 1'b0;
         wait_hi(2);
         run_random(30);
         stop_n = 1'b1;
         wait_hi(3);
      end
      give_verdict();
   end
endmodule // test_bus_response_target_ready
